/* File: design/pic_top.sv */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
// What this block does
// - Each internal source can be silenced by its own enable input or by a mask bit in this block.
// - Of several pending requests only the single best one is presented to the processor.
// - A request of higher priority than the one in service is still forwarded, allowing nesting.
// - Bit 14 of the relocation register selects slave mode, which only halts master delivery; the slave protocol is not implemented.
// - Five external pins are taken: one non-maskable request and four maskable lines.
// - The four maskable pins act as four direct lines, one cascade pair plus two lines, or two cascade pairs.
// - A cascade source is acknowledged by two consecutive acknowledge cycles and the vector is taken on the second.
// - Cascade sources get vectors from the external controller, all others get internal vectors.
// - Internal request handling is the same in every master configuration.
// - The configuration is set by a mode bit in each of the two external-pair control registers.
// - In fully nested mode all four maskable pins are direct requests with internal vectors.
// - One in-service flag per source is set while that source is being serviced.
// - While a flag is set no interrupt is raised for a lower-priority request.
// - While a source's flag is set a new request from that source raises no interrupt.
// - Each source has a 3-bit priority, smaller value wins.
// - Each source has a default priority and equal levels are broken by fixed source order.
module pic_top (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Internal sources and their enables
    input  wire logic [4:0]  int_req_in,
    input  wire logic [4:0]  int_en_in,
    // External pins
    input  wire logic        nmi_in,
    input  wire logic [3:0]  external_request_line_in,
    input  wire logic [7:0]  cascade_vector_in,
    output logic      [1:0]  vector_acknowledge_cycle_out,
    // Processor side
    output logic             cpu_int_out,
    output logic             cpu_nmi_out,
    input  wire logic        cpu_ack_in,
    output logic      [7:0]  cpu_vector_out,
    output logic             cpu_vector_valid_out,
    output logic             slave_mode_out,
    // Interrupt of the block itself
    output logic             irq_out
);
    logic [pic_pkg::NSRC-1:0]   mask_r;
    logic [pic_pkg::NSRC-1:0]   in_service_flag_r;
    logic [2:0]                 prio_r [pic_pkg::NSRC];
    logic [31:0]                reloc_r;
    logic                       ext_pair0_control_r;
    logic                       ext_pair1_control_r;
    logic [pic_pkg::IRQ_W-1:0]  irq_stat_r;
    logic [pic_pkg::IRQ_W-1:0]  irq_mask_r;
    logic [7:0]                 last_vec_r;
    pic_pkg::pic_state_t        state_r;
    logic [pic_pkg::SRC_W-1:0]  cur_src_r;
    logic                       nmi_prev_r;
    logic                       cpu_nmi_r;
    logic [pic_pkg::NSRC-1:0]   raw_req;
    logic [pic_pkg::NSRC-1:0]   cascade_src;
    logic [pic_pkg::NSRC-1:0]   eligible;
    logic [pic_pkg::SRC_W-1:0]  best_src;
    logic [2:0]                 best_lvl;
    logic                       best_any;
    logic [2:0]                 serv_lvl;
    logic                       serv_any;
    logic [pic_pkg::SRC_W-1:0]  serv_src;
    logic                       wr_en;
    logic                       eoi_wr;
    logic                       take_ack;
    logic [1:0]                 acked_pair;

    assign wr_en  = psel_in && penable_in && pwrite_in && pready_out;
    assign eoi_wr = wr_en && (paddr_in == pic_pkg::OFF_EOI);

    // Pin 0 pairs with pin 1 as request/acknowledge; pin 2 with pin 3
    always_comb begin
        cascade_src = '0;
        cascade_src[pic_pkg::EXT_BASE]     = ext_pair0_control_r;
        cascade_src[pic_pkg::EXT_BASE + 2] = ext_pair1_control_r;
    end

    always_comb begin
        raw_req = '0;
        raw_req[4:0] = int_req_in & int_en_in;
        raw_req[pic_pkg::EXT_BASE]     = external_request_line_in[0];
        raw_req[pic_pkg::EXT_BASE + 1] = external_request_line_in[1] && !ext_pair0_control_r;
        raw_req[pic_pkg::EXT_BASE + 2] = external_request_line_in[2];
        raw_req[pic_pkg::EXT_BASE + 3] = external_request_line_in[3] && !ext_pair1_control_r;
    end

    // Highest-priority in-service source; lower index wins ties
    always_comb begin
        serv_lvl = pic_pkg::LVL_NONE;
        serv_any = 1'b0;
        serv_src = '0;
        for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
            if (in_service_flag_r[i] && (!serv_any || prio_r[i] <= serv_lvl)) begin
                serv_lvl = prio_r[i];
                serv_any = 1'b1;
                serv_src = pic_pkg::SRC_W'(i);
            end
        end
    end

    // Only strictly higher priority than anything in service may pass
    always_comb begin
        for (int i = 0; i < pic_pkg::NSRC; i++) begin
            eligible[i] = raw_req[i] && !mask_r[i] && !in_service_flag_r[i]
                          && (!serv_any || prio_r[i] < serv_lvl);
        end
    end

    // Scan downward so the lowest index wins among equal levels
    always_comb begin
        best_lvl = pic_pkg::LVL_NONE;
        best_any = 1'b0;
        best_src = '0;
        for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!best_any || prio_r[i] <= best_lvl)) begin
                best_lvl = prio_r[i];
                best_any = 1'b1;
                best_src = pic_pkg::SRC_W'(i);
            end
        end
    end

    assign take_ack   = (state_r == pic_pkg::PIC_REQ) && cpu_int_out && cpu_ack_in;
    assign acked_pair = (cur_src_r == pic_pkg::SRC_W'(pic_pkg::EXT_BASE)) ? 2'h1 : 2'h2;

    // Slave mode halts master delivery; its protocol is not implemented
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r   <= pic_pkg::PIC_IDLE;
            cur_src_r <= '0;
        end else begin
            unique case (state_r)
                pic_pkg::PIC_IDLE: begin
                    if (best_any && !reloc_r[pic_pkg::RELOC_SLAVE_BIT]) begin
                        state_r   <= pic_pkg::PIC_REQ;
                        cur_src_r <= best_src;
                    end
                end
                pic_pkg::PIC_REQ: begin
                    if (take_ack) begin
                        state_r <= cascade_src[cur_src_r] ? pic_pkg::PIC_ACK1 : pic_pkg::PIC_IDLE;
                    end else if (!best_any || reloc_r[pic_pkg::RELOC_SLAVE_BIT]) begin
                        state_r <= pic_pkg::PIC_IDLE;
                    end else begin
                        cur_src_r <= best_src;
                    end
                end
                pic_pkg::PIC_ACK1: state_r <= pic_pkg::PIC_ACK2;
                pic_pkg::PIC_ACK2: state_r <= pic_pkg::PIC_IDLE;
                default:           state_r <= pic_pkg::PIC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            vector_acknowledge_cycle_out <= 2'h0;
        end else if (take_ack && cascade_src[cur_src_r]) begin
            vector_acknowledge_cycle_out <= acked_pair;
        end else if (state_r == pic_pkg::PIC_ACK1) begin
            vector_acknowledge_cycle_out <= vector_acknowledge_cycle_out;
        end else begin
            vector_acknowledge_cycle_out <= 2'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cpu_vector_out       <= 8'h00;
            cpu_vector_valid_out <= 1'b0;
        end else if (take_ack && !cascade_src[cur_src_r]) begin
            cpu_vector_out       <= pic_pkg::VEC_BASE + 8'(cur_src_r);
            cpu_vector_valid_out <= 1'b1;
        end else if (state_r == pic_pkg::PIC_ACK2) begin
            cpu_vector_out       <= cascade_vector_in;
            cpu_vector_valid_out <= 1'b1;
        end else begin
            cpu_vector_valid_out <= 1'b0;
        end
    end

    // Last vector handed over, kept for software
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            last_vec_r <= 8'h00;
        end else if (take_ack && !cascade_src[cur_src_r]) begin
            last_vec_r <= pic_pkg::VEC_BASE + 8'(cur_src_r);
        end else if (state_r == pic_pkg::PIC_ACK2) begin
            last_vec_r <= cascade_vector_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cpu_int_out <= 1'b0;
        end else begin
            cpu_int_out <= (state_r == pic_pkg::PIC_IDLE || state_r == pic_pkg::PIC_REQ)
                           && best_any && !reloc_r[pic_pkg::RELOC_SLAVE_BIT] && !take_ack;
        end
    end

    // Non-maskable pin bypasses mask and priority; rising edge pulses
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            nmi_prev_r  <= 1'b0;
            cpu_nmi_r   <= 1'b0;
            cpu_nmi_out <= 1'b0;
        end else begin
            nmi_prev_r  <= nmi_in;
            cpu_nmi_r   <= nmi_in && !nmi_prev_r;
            cpu_nmi_out <= cpu_nmi_r;
        end
    end

    // Acknowledge sets in-service; set wins over an end-of-interrupt clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            in_service_flag_r <= '0;
        end else begin
            for (int i = 0; i < pic_pkg::NSRC; i++) begin
                if (take_ack && cur_src_r == pic_pkg::SRC_W'(i)) begin
                    in_service_flag_r[i] <= 1'b1;
                end else if (eoi_wr && serv_any && serv_src == pic_pkg::SRC_W'(i)) begin
                    in_service_flag_r[i] <= 1'b0;
                end
            end
        end
    end

    // Own events: acknowledge taken, end-of-interrupt taken
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_stat_r <= '0;
        end else begin
            for (int i = 0; i < pic_pkg::IRQ_W; i++) begin
                if ((i == pic_pkg::IRQ_ACK && take_ack) || (i == pic_pkg::IRQ_EOI && eoi_wr)) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (wr_en && paddr_in == pic_pkg::OFF_IRQSTAT && pwdata_in[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Source masks and own interrupt mask
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_r     <= pic_pkg::MASK_RST;
            irq_mask_r <= '0;
        end else if (wr_en && paddr_in == pic_pkg::OFF_MASK) begin
            mask_r <= pwdata_in[pic_pkg::NSRC-1:0];
        end else if (wr_en && paddr_in == pic_pkg::OFF_IRQMASK) begin
            irq_mask_r <= pwdata_in[pic_pkg::IRQ_W-1:0];
        end
    end

    // Operating mode: relocation word and pair configuration
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reloc_r             <= '0;
            ext_pair0_control_r <= 1'b0;
            ext_pair1_control_r <= 1'b0;
        end else if (wr_en) begin
            if (paddr_in == pic_pkg::OFF_RELOC) begin
                reloc_r <= pwdata_in;
            end
            if (paddr_in == pic_pkg::OFF_PAIR0) begin
                ext_pair0_control_r <= pwdata_in[pic_pkg::PAIR_CASC_BIT];
            end
            if (paddr_in == pic_pkg::OFF_PAIR1) begin
                ext_pair1_control_r <= pwdata_in[pic_pkg::PAIR_CASC_BIT];
            end
        end
    end

    // Priority levels, one word per source
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < pic_pkg::NSRC; i++) begin
                prio_r[i] <= pic_pkg::PRIO_RST;
            end
        end else if (wr_en) begin
            for (int i = 0; i < pic_pkg::NSRC; i++) begin
                if (paddr_in == pic_pkg::OFF_PRIO0 + 12'(4 * i)) begin
                    prio_r[i] <= pwdata_in[pic_pkg::PRIO_W-1:0];
                end
            end
        end
    end

    // One wait state: every access answers on its second access cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out <= '0;
        end else if (psel_in && penable_in && !pwrite_in && !pready_out) begin
            prdata_out <= '0;
            unique case (paddr_in)
                pic_pkg::OFF_MASK:    prdata_out[pic_pkg::NSRC-1:0] <= mask_r;
                pic_pkg::OFF_STATUS:  prdata_out[pic_pkg::NSRC-1:0] <= raw_req;
                pic_pkg::OFF_INSERV:  prdata_out[pic_pkg::NSRC-1:0] <= in_service_flag_r;
                pic_pkg::OFF_RELOC:   prdata_out <= reloc_r;
                pic_pkg::OFF_PAIR0:   prdata_out[pic_pkg::PAIR_CASC_BIT] <= ext_pair0_control_r;
                pic_pkg::OFF_PAIR1:   prdata_out[pic_pkg::PAIR_CASC_BIT] <= ext_pair1_control_r;
                pic_pkg::OFF_IRQSTAT: prdata_out[pic_pkg::IRQ_W-1:0] <= irq_stat_r;
                pic_pkg::OFF_IRQMASK: prdata_out[pic_pkg::IRQ_W-1:0] <= irq_mask_r;
                pic_pkg::OFF_VECTOR:  prdata_out[7:0] <= last_vec_r;
                default: begin
                    for (int i = 0; i < pic_pkg::NSRC; i++) begin
                        if (paddr_in == pic_pkg::OFF_PRIO0 + 12'(4 * i)) begin
                            prdata_out[pic_pkg::PRIO_W-1:0] <= prio_r[i];
                        end
                    end
                end
            endcase
        end
    end

    assign slave_mode_out = reloc_r[pic_pkg::RELOC_SLAVE_BIT];
endmodule : pic_top

/* File: design/pic_pkg.sv */
package pic_pkg;
    // Sources: 0 timer0, 1 timer1, 2 timer2, 3 dma0, 4 dma1, 5..8 external lines 0..3
    localparam int NSRC      = 9;
    localparam int NUM_INT   = 5;
    localparam int EXT_BASE  = 5;
    localparam int SRC_W     = 4;
    // Register byte offsets
    localparam logic [11:0] OFF_MASK    = 12'h000;
    localparam logic [11:0] OFF_STATUS  = 12'h004;
    localparam logic [11:0] OFF_INSERV  = 12'h008;
    localparam logic [11:0] OFF_EOI     = 12'h00C;
    localparam logic [11:0] OFF_RELOC   = 12'h010;
    localparam logic [11:0] OFF_PAIR0   = 12'h014;
    localparam logic [11:0] OFF_PAIR1   = 12'h018;
    localparam logic [11:0] OFF_IRQSTAT = 12'h01C;
    localparam logic [11:0] OFF_IRQMASK = 12'h020;
    localparam logic [11:0] OFF_VECTOR  = 12'h024;
    localparam logic [11:0] OFF_PRIO0   = 12'h040;
    // Field positions and widths
    localparam int RELOC_SLAVE_BIT = 14;
    localparam int PAIR_CASC_BIT   = 0;
    localparam int PRIO_W          = 3;
    localparam int IRQ_W           = 2;
    localparam int IRQ_ACK         = 0;
    localparam int IRQ_EOI         = 1;
    // Reset values, vector constants, the no-level marker and the state type
    localparam logic [NSRC-1:0] MASK_RST  = 9'h1FF;
    localparam logic [2:0]      PRIO_RST  = 3'h7;
    localparam logic [7:0]      VEC_BASE  = 8'h08;
    localparam logic [7:0]      NMI_VEC   = 8'h02;
    localparam logic [2:0]      LVL_NONE  = 3'h7;
    typedef enum logic [2:0] {PIC_IDLE, PIC_REQ, PIC_ACK1, PIC_GAP, PIC_ACK2} pic_state_t;
endpackage : pic_pkg

/* File: dv/pic_sva.sv */
`timescale 1ns/100ps
module pic_sva (
    // Watched ports
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       psel_in,
    input  wire logic       penable_in,
    input  wire logic       pready_out,
    input  wire logic       pslverr_out,
    input  wire logic       nmi_in,
    input  wire logic [7:0] cascade_vector_in,
    input  wire logic [1:0] vector_acknowledge_cycle_out,
    input  wire logic       cpu_int_out,
    input  wire logic       cpu_nmi_out,
    input  wire logic       cpu_ack_in,
    input  wire logic [7:0] cpu_vector_out,
    input  wire logic       cpu_vector_valid_out,
    input  wire logic       slave_mode_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("pready longer than one cycle");
    no_error_a: assert property (!pslverr_out) else $error("pslverr raised");
    int_drop_a: assert property (cpu_ack_in && cpu_int_out |=> !cpu_int_out) else $error("int held after ack");
    vec_path_a: assert property (cpu_ack_in && cpu_int_out |=>
        cpu_vector_valid_out ^ (|vector_acknowledge_cycle_out)) else $error("ack answered on wrong path");
    casc_ack_a: assert property ($rose(vector_acknowledge_cycle_out[0]) |=>
        vector_acknowledge_cycle_out[0] ##1 !vector_acknowledge_cycle_out[0]) else $error("ack not two cycles");
    casc_ack1_a: assert property ($rose(vector_acknowledge_cycle_out[1]) |=>
        vector_acknowledge_cycle_out[1] ##1 !vector_acknowledge_cycle_out[1]) else $error("pair1 ack not two cycles");
    casc_vec_a: assert property ($rose(|vector_acknowledge_cycle_out) ##1 (|vector_acknowledge_cycle_out) |=>
        cpu_vector_valid_out && cpu_vector_out == $past(cascade_vector_in)) else $error("cascade vector");
    ack_excl_a: assert property (!(&vector_acknowledge_cycle_out)) else $error("both pairs acked");
    nmi_pulse_a: assert property ($rose(nmi_in) |-> ##[2:3] cpu_nmi_out) else $error("nmi not forwarded");
    slave_hold_a: assert property ($rose(cpu_int_out) |-> !$past(slave_mode_out))
        else $error("int raised in slave mode");
    cover property ($rose(|vector_acknowledge_cycle_out));
    cover property (cpu_nmi_out);
    cover property (cpu_ack_in && cpu_int_out);
    cover property (slave_mode_out);
endmodule : pic_sva
bind pic_top pic_sva i_sva (.*);

/* File: dv/pic_casc_model.sv */
`timescale 1ns/100ps
module pic_casc_model #(
    parameter logic [7:0] VEC = 8'hA5
) (
    // Clock, acknowledge, request
    input  wire logic       clk_in,
    input  wire logic       ack_in,
    input  wire logic       req_in,
    output logic            req_out,
    // Vector bus
    output logic      [7:0] vector_out
);
    logic       second_r;
    logic [7:0] junk_r = 8'h5A;
    assign req_out = req_in;
    always_ff @(posedge clk_in) begin
        second_r <= ack_in && !second_r;
    end
    // Bus is undriven outside the second cycle, so show a changing pattern
    always_ff @(posedge clk_in) begin
        junk_r <= ~junk_r;
    end
    assign vector_out = (ack_in && second_r) ? VEC : junk_r;
endmodule : pic_casc_model

/* File: dv/priority_interrupt_controller_tb.sv */
`timescale 1ns/100ps
module priority_interrupt_controller_tb;
    localparam logic [7:0] CASC_VEC = 8'hA5;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, nmi = 0, cpu_ack = 0, casc_req = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic [4:0]  int_req = 5'h00, int_en = 5'h00;
    logic [3:1]  ext = 3'h0;
    logic [31:0] prdata;
    logic        pready, cpu_int, cpu_nmi, vld, slave, irq, creq;
    logic [7:0]  vec, cvec;
    logic [1:0]  vack;
    int          fails = 0, n_compared = 0, cyc = 0;
    always #2.5 clk = ~clk;
    pic_top i_dut (.clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
        .int_req_in(int_req), .int_en_in(int_en), .nmi_in(nmi), .external_request_line_in({ext, creq}),
        .cascade_vector_in(cvec), .vector_acknowledge_cycle_out(vack), .cpu_int_out(cpu_int),
        .cpu_nmi_out(cpu_nmi), .cpu_ack_in(cpu_ack), .cpu_vector_out(vec), .cpu_vector_valid_out(vld),
        .slave_mode_out(slave), .irq_out(irq));
    pic_casc_model #(.VEC(CASC_VEC)) i_casc (.clk_in(clk), .ack_in(|vack), .req_in(casc_req),
        .req_out(creq), .vector_out(cvec));
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, q);
    endtask : rdc
    task automatic svc(input logic [7:0] v);
        int i;
        for (i = 0; i < 40 && cpu_int !== 1'b1; i++) @(posedge clk);
        chk("cpu_int", 32'h1, {31'h0, cpu_int});
        cpu_ack <= 1'b1;
        @(posedge clk);
        cpu_ack <= 1'b0;
        for (i = 0; i < 8 && vld !== 1'b1; i++) @(posedge clk);
        chk("valid", 32'h1, {31'h0, vld});
        chk("vector", {24'h0, v}, {24'h0, vec});
    endtask : svc
    task automatic quiet;
        repeat (6) @(posedge clk);
        chk("cpu_int", 32'h0, {31'h0, cpu_int});
    endtask : quiet
    task automatic eoi;
        apb(1'b1, pic_pkg::OFF_EOI, 32'h0);
    endtask : eoi
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdc(pic_pkg::OFF_MASK, 32'h1FF);
        rdc(pic_pkg::OFF_PRIO0 + 12'h00C, 32'h7);
        rdc(12'h030, 32'h0);
        $display("test reset done");
        apb(1'b1, pic_pkg::OFF_MASK, 32'h0);
        apb(1'b1, pic_pkg::OFF_IRQMASK, 32'h3);
        int_req <= 5'h01;
        quiet();
        apb(1'b1, pic_pkg::OFF_MASK, 32'h1);
        int_en <= 5'h1F;
        quiet();
        apb(1'b1, pic_pkg::OFF_MASK, 32'h0);
        svc(pic_pkg::VEC_BASE);
        rdc(pic_pkg::OFF_INSERV, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        quiet();
        eoi();
        rdc(pic_pkg::OFF_INSERV, 32'h0);
        svc(pic_pkg::VEC_BASE);
        int_req <= 5'h00;
        eoi();
        apb(1'b1, pic_pkg::OFF_IRQSTAT, 32'h3);
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test service done");
        apb(1'b1, pic_pkg::OFF_PRIO0 + 12'h004, 32'h2);
        apb(1'b1, pic_pkg::OFF_PRIO0 + 12'h00C, 32'h5);
        int_req <= 5'h0A;
        svc(pic_pkg::VEC_BASE + 8'h01);
        quiet();
        apb(1'b1, pic_pkg::OFF_PRIO0, 32'h1);
        int_req <= 5'h0B;
        svc(pic_pkg::VEC_BASE);
        int_req <= 5'h00;
        eoi();
        rdc(pic_pkg::OFF_INSERV, 32'h2);
        eoi();
        apb(1'b1, pic_pkg::OFF_PRIO0 + 12'h004, 32'h1);
        int_req <= 5'h03;
        svc(pic_pkg::VEC_BASE);
        int_req <= 5'h00;
        eoi();
        $display("test priority done");
        apb(1'b1, pic_pkg::OFF_PAIR0, 32'h1);
        casc_req <= 1'b1;
        svc(CASC_VEC);
        casc_req <= 1'b0;
        eoi();
        ext <= 3'b100;
        svc(pic_pkg::VEC_BASE + 8'h08);
        ext <= 3'b000;
        eoi();
        apb(1'b1, pic_pkg::OFF_PAIR1, 32'h1);
        ext <= 3'b010;
        svc(CASC_VEC);
        rdc(pic_pkg::OFF_VECTOR, {24'h0, CASC_VEC});
        ext <= 3'b000;
        eoi();
        apb(1'b1, pic_pkg::OFF_PAIR0, 32'h0);
        apb(1'b1, pic_pkg::OFF_PAIR1, 32'h0);
        casc_req <= 1'b1;
        svc(pic_pkg::VEC_BASE + 8'h05);
        casc_req <= 1'b0;
        eoi();
        $display("test external done");
        apb(1'b1, pic_pkg::OFF_MASK, 32'h1FF);
        nmi <= 1'b1;
        for (int i = 0; i < 5 && cpu_nmi !== 1'b1; i++) @(posedge clk);
        chk("cpu_nmi", 32'h1, {31'h0, cpu_nmi});
        nmi <= 1'b0;
        apb(1'b1, pic_pkg::OFF_RELOC, 32'h4000);
        chk("slave", 32'h1, {31'h0, slave});
        apb(1'b1, pic_pkg::OFF_MASK, 32'h0);
        int_req <= 5'h01;
        quiet();
        $display("test nmi and slave done");
        report_and_stop();
    end
endmodule : priority_interrupt_controller_tb
